/* File: logic/pff_top.sv */
// Purpose: Fault override and interrupt gating of a six-channel PWM
// Assumes: Generator inputs share clk; fault pin is asynchronous
// Notes: All outputs registered; one cycle from pwmGen to pin, three from faultPin
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pff_consts.svh"

module pff_top
  import pff_pkg::*;
#(
  parameter int CHANNELS = `PFF_CHANNELS,
  parameter int GENS     = `PFF_GENS
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Wishbone slave
  input  wire pff_wbreq_t          wbReq,
  output var  logic                wbAck,
  output var  logic [31:0]         wbDatO,
  // Generator side
  input  wire logic [CHANNELS-1:0] pwmGen,
  input  wire logic [GENS-1:0]     genIrq,
  input  wire logic                debugEvent,
  // Fault pin
  input  wire logic                faultPin,
  // Pins and interrupt
  output var  logic [CHANNELS-1:0] pwmPin,
  output var  logic                irqOut
);

  logic [1:0]          faultMeta;
  logic                faultSync;
  logic                faultCond;
  logic [CHANNELS-1:0] forceLow;
  logic [CHANNELS-1:0] invert;
  logic [31:0]         intEnable;
  logic                faultLatch;
  logic                access;
  logic                wrAccess;
  logic                clrFault;
  logic [31:0]         rawStatus;
  logic [31:0]         maskStatus;
  logic [CHANNELS-1:0] forcedGen;
  logic [31:0]         next_rdData;
  logic                rstLag;

  // Register address decode
  function automatic logic hit(input logic [`PFF_ADR_W-1:0] adr,
                               input logic [`PFF_ADR_W-1:0] ofs);
    hit = (adr == ofs);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // Fault pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultMeta <= 2'h0;
    end else begin
      faultMeta <= {faultMeta[0], faultPin};
    end
  end
  assign faultSync = faultMeta[1];

  assign faultCond = faultSync | debugEvent;

  assign access   = wbReq.cyc & wbReq.stb & ~wbAck;
  assign wrAccess = access & wbReq.we;

  // Bus acknowledge, one cycle after request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= access;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forceLow <= CHANNELS'(`PFF_RST_VALUE);
    end else if (wrAccess && hit(wbReq.adr, `PFF_OFS_FORCE)) begin
      forceLow <= CHANNELS'(merge(32'(forceLow), wbReq.dat,
                                  wbReq.sel) & `PFF_CH_MASK);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      invert <= CHANNELS'(`PFF_RST_VALUE);
    end else if (wrAccess && hit(wbReq.adr, `PFF_OFS_INVERT)) begin
      invert <= CHANNELS'(merge(32'(invert), wbReq.dat,
                                wbReq.sel) & `PFF_CH_MASK);
    end
  end

  // Enable register, reserved bits kept zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEnable <= `PFF_RST_VALUE;
    end else if (wrAccess && hit(wbReq.adr, `PFF_OFS_ENABLE)) begin
      intEnable <= merge(intEnable, wbReq.dat, wbReq.sel) & `PFF_EN_MASK;
    end
  end

  assign clrFault = wrAccess && hit(wbReq.adr, `PFF_OFS_ISC)
                    && wbReq.sel[2] && wbReq.dat[`PFF_FAULT_BIT];

  // Latch fault, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultLatch <= 1'b0;
    end else if (faultSync) begin
      faultLatch <= 1'b1;
    end else if (clrFault) begin
      faultLatch <= 1'b0;
    end
  end

  always_comb begin
    rawStatus = 32'h0000_0000;
    rawStatus[`PFF_FAULT_BIT] = faultLatch;
    rawStatus[GENS-1:0] = genIrq;
  end
  assign maskStatus = rawStatus & intEnable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |maskStatus;
    end
  end

  // Output stage per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gOut
      assign forcedGen[ch] = pwmGen[ch] & ~(forceLow[ch] & faultCond);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pwmPin[ch] <= 1'b0;
        end else begin
          pwmPin[ch] <= forcedGen[ch] ^ invert[ch];
        end
      end
    end
  endgenerate

  // Read data mux
  always_comb begin
    next_rdData = 32'h0000_0000;
    if (hit(wbReq.adr, `PFF_OFS_INVERT)) begin
      next_rdData = 32'(invert);
    end else if (hit(wbReq.adr, `PFF_OFS_FORCE)) begin
      next_rdData = 32'(forceLow);
    end else if (hit(wbReq.adr, `PFF_OFS_ENABLE)) begin
      next_rdData = intEnable;
    end else if (hit(wbReq.adr, `PFF_OFS_RAW)) begin
      next_rdData = rawStatus;
    end else if (hit(wbReq.adr, `PFF_OFS_ISC)) begin
      next_rdData = maskStatus;
    end else if (hit(wbReq.adr, `PFF_OFS_STATUS)) begin
      next_rdData = {31'h0, faultSync};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbDatO <= 32'h0000_0000;
    end else if (access && !wbReq.we) begin
      wbDatO <= next_rdData;
    end else begin
      wbDatO <= 32'h0000_0000;
    end
  end

  // Masks checks for the first edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstLag <= 1'b1;
    end else begin
      rstLag <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rstLag);

  sequence clearWrite;
    clrFault && !faultSync;
  endsequence

  sequence faultSeen;
    faultSync ##1 faultLatch;
  endsequence

  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChk
      forceLow_a: assert property (
        (faultCond && forceLow[ch]) |=> (pwmPin[ch] == $past(invert[ch])))
        else $error("forced channel not Low before inverter");
      passThru_a: assert property (
        (!faultCond || !forceLow[ch])
          |=> (pwmPin[ch] == ($past(pwmGen[ch]) ^ $past(invert[ch]))))
        else $error("channel not passed through");
      invertHigh_a: assert property (
        (faultCond && forceLow[ch] && invert[ch]) |=> pwmPin[ch])
        else $error("inverted forced channel not High");
      debugForce_a: assert property (
        (debugEvent && forceLow[ch]) |=> (pwmPin[ch] == $past(invert[ch])))
        else $error("debug event did not force channel");
    end
  endgenerate

  irqGate_a: assert property (
    (intEnable == 32'h0000_0000) |=> !irqOut)
    else $error("interrupt raised with no source enabled");

  faultIrq_a: assert property (
    (faultLatch && intEnable[`PFF_FAULT_BIT]) |=> irqOut)
    else $error("enabled fault did not raise interrupt");

  faultMask_a: assert property (
    (!intEnable[`PFF_FAULT_BIT] && ((genIrq & intEnable[GENS-1:0]) == 0))
      |=> !irqOut)
    else $error("disabled fault raised interrupt");

  genIrq_a: assert property (
    ((genIrq & intEnable[GENS-1:0]) != 0) |=> irqOut)
    else $error("enabled generator did not raise interrupt");

  faultSet_a: assert property (
    faultSync |-> faultSeen)
    else $error("fault status not latched");

  faultLatch_a: assert property (
    (faultLatch && !clrFault) |=> faultLatch)
    else $error("fault status lost before clear");

  faultClear_a: assert property (
    clearWrite |=> !faultLatch)
    else $error("fault status not cleared by write one");

  faultSync_a: assert property (
    faultSync == $past(faultPin, 2))
    else $error("fault pin not synchronised in two stages");

  reserved_a: assert property (
    ((intEnable & ~`PFF_EN_MASK) == 32'h0000_0000))
    else $error("reserved enable bit set");

  latchDebug_a: assert property (
    (!faultSync && !faultLatch) |=> !faultLatch)
    else $error("fault status set without fault pin");

  irqSrc_a: assert property (
    (maskStatus == 32'h0000_0000) |=> !irqOut)
    else $error("interrupt raised with no enabled source");

  ackPulse_a: assert property (
    wbAck |=> !wbAck)
    else $error("acknowledge longer than one cycle");

  ackTaken_a: assert property (
    access |=> wbAck)
    else $error("request not acknowledged");

  rdIdle_a: assert property (
    !wbAck |-> (wbDatO == 32'h0000_0000))
    else $error("read data outside acknowledge");

  enWrite_a: assert property (
    (wrAccess && hit(wbReq.adr, `PFF_OFS_ENABLE) && (wbReq.sel == 4'hF))
      |=> (intEnable == ($past(wbReq.dat) & `PFF_EN_MASK)))
    else $error("enable write not committed");

  enRead_a: assert property (
    (access && !wbReq.we && hit(wbReq.adr, `PFF_OFS_ENABLE))
      |=> (wbDatO == $past(intEnable)))
    else $error("enable read data wrong");

endmodule

`default_nettype wire

/* File: logic/pff_consts.svh */
// Purpose: Offsets, field positions and reset values of the fault block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:
// Operation
// - Force-bit set: channel Low during fault
// - Enable register gates single interrupt output
// - Bit 16 lets fault raise interrupt
// - Bits 2..0 let generators raise interrupt
// - Fault input or debug is fault; else pass
// - Forcing happens before the output inverter
// - Fault status latched until write-one clears
`ifndef PFF_CONSTS_SVH
`define PFF_CONSTS_SVH

`define PFF_ADR_W        8
`define PFF_OFS_INVERT   8'h0C
`define PFF_OFS_FORCE    8'h10
`define PFF_OFS_ENABLE   8'h14
`define PFF_OFS_RAW      8'h18
`define PFF_OFS_ISC      8'h1C
`define PFF_OFS_STATUS   8'h20
`define PFF_CHANNELS     6
`define PFF_GENS         3
`define PFF_FAULT_BIT    16
`define PFF_CH_MASK      32'h0000_003F
`define PFF_EN_MASK      32'h0001_0007
`define PFF_RST_VALUE    32'h0000_0000

`endif

/* File: logic/pff_pkg.sv */
// Purpose: Types shared by the fault block
// Assumes: Constants come from pff_consts.svh
// Notes: Wishbone request travels as one struct
`default_nettype none
`include "pff_consts.svh"
package pff_pkg;
  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`PFF_ADR_W-1:0]  adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } pff_wbreq_t;
endpackage
`default_nettype wire

/* File: tb/pff_far_model.sv */
// Purpose: Pin and interrupt controller model
// Assumes: Samples on the clk rising edge
// Notes: Holds what the far side last saw
`timescale 1ns/10ps
`default_nettype none
module pff_far_model (
  // Clock
  input  wire logic       clk,
  // From block
  input  wire logic [5:0] pwmPin,
  input  wire logic       irqOut,
  // Seen values
  output var  logic [5:0] pinSeen,
  output var  logic       irqSeen
);
  always_ff @(posedge clk) begin
    pinSeen <= pwmPin;
    irqSeen <= irqOut;
  end
endmodule
`default_nettype wire

/* File: tb/test_pff_top.sv */
// Purpose: Self-checking bench of the fault block
// Assumes: Bench timeout bounds every bus wait
// Notes: Rows cover the output path; hand tests follow
`timescale 1ns/10ps
`default_nettype none
`include "pff_consts.svh"
module test_pff_top
  import pff_pkg::*;
;
  typedef struct packed {
    logic [5:0] frc, inv, gen, exp;
    logic       flt, dbg;
  } pff_row_t;
  logic        clk = 0, rst = 1, debugEvent = 0, faultPin = 0;
  logic        wbAck, irqOut, irqSeen;
  pff_wbreq_t  wbReq = '0;
  logic [31:0] wbDatO, q;
  logic [5:0]  pwmGen = '0, pwmPin, pinSeen;
  logic [2:0]  genIrq = '0;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  pff_row_t    rows [6] = '{
    '{6'h00, 6'h00, 6'h2A, 6'h2A, 1'b0, 1'b1},
    '{6'h3F, 6'h00, 6'h3F, 6'h00, 1'b0, 1'b1},
    '{6'h15, 6'h00, 6'h3F, 6'h2A, 1'b1, 1'b0},
    '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 1'b0, 1'b1},
    '{6'h3F, 6'h0C, 6'h15, 6'h19, 1'b0, 1'b0},
    '{6'h0F, 6'h30, 6'h3F, 6'h00, 1'b0, 1'b1}};
  pff_top i_pff_top (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatO(wbDatO), .pwmGen(pwmGen), .genIrq(genIrq),
    .debugEvent(debugEvent), .faultPin(faultPin), .pwmPin(pwmPin),
    .irqOut(irqOut));
  pff_far_model i_pff_far_model (.clk(clk), .pwmPin(pwmPin),
    .irqOut(irqOut), .pinSeen(pinSeen), .irqSeen(irqSeen));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbReq <= '0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    tick(20);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wb(1'b1, `PFF_OFS_FORCE, 32'(rows[i].frc));
      wb(1'b1, `PFF_OFS_INVERT, 32'(rows[i].inv));
      pwmGen <= rows[i].gen;
      faultPin <= rows[i].flt;
      debugEvent <= rows[i].dbg;
      tick(5);
      chk(32'(pinSeen), 32'(rows[i].exp));
      chkb(irqSeen, 1'b0);
    end
    faultPin <= 1'b0;
    debugEvent <= 1'b0;
    wb(1'b1, `PFF_OFS_ENABLE, 32'hFFFF_FFFF);
    wb(1'b0, `PFF_OFS_ENABLE, '0);
    chk(q, `PFF_EN_MASK);
    chkb(irqSeen, 1'b1);
    wb(1'b1, `PFF_OFS_ISC, 32'h0001_0000);
    tick(3);
    chkb(irqSeen, 1'b0);
    for (int i = 0; i < 3; i++) begin
      genIrq <= 3'(1 << i);
      tick(3);
      chkb(irqSeen, 1'b1);
    end
    wb(1'b1, `PFF_OFS_ENABLE, 32'h0001_0000);
    tick(3);
    chkb(irqSeen, 1'b0);
    genIrq <= '0;
    faultPin <= 1'b1;
    tick(1);
    faultPin <= 1'b0;
    tick(6);
    chkb(irqSeen, 1'b1);
    wb(1'b0, `PFF_OFS_RAW, '0);
    chk(q, 32'h0001_0000);
    wb(1'b1, `PFF_OFS_ISC, 32'h0001_0000);
    tick(3);
    chkb(irqSeen, 1'b0);
    wb(1'b0, 8'h40, '0);
    chk(q, '0);
    tick(1);
    chkb(wbAck, 1'b0);
    rst <= 1'b1;
    tick(2);
    chk(32'(pinSeen), '0);
    chkb(irqSeen, 1'b0);
    rst <= 1'b0;
    wb(1'b0, `PFF_OFS_FORCE, '0);
    chk(q, `PFF_RST_VALUE);
    wb(1'b0, `PFF_OFS_ENABLE, '0);
    chk(q, `PFF_RST_VALUE);
    chk(32'(pinSeen), 32'(pwmGen));
    tally_and_finish();
  end
endmodule
`default_nettype wire
